//--- ptp_gpio_trigger_timestamp_ctrl.v
// Summary of operation
// - trigger fields 2-bit indexed, capture 1-bit indexed
// - out select: one combinational, zero flopped
// - pin monitor reads live gpio input
// - direction: one trigger, zero capture; reset zero
// - per-unit capture interrupt enable gates irq
// - active reads one while armed unit runs
// - enable arms unit, self-clears on fire
// - trigger soft reset returns unit inactive
// - capture enable one clears event counter
// - capture enable zero clears ready, overflow
// - capture soft reset returns unit inactive
// - 30-bit nanosecond target per unit, reset zero
// - 32-bit seconds target per unit, reset zero
// - notify: fire sets done, w1c, irq
// Purpose: gpio trigger / timestamp unit control over axi4-lite
// Assumes: ptp time and gpio input synchronous to MCLK
// Notes:   status register clears on read; GPIO_OUT/OE flopped
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ptp_trig_consts.vh"
module ptp_gpio_trigger_timestamp_ctrl (
  input  wire        MCLK,
  input  wire        RESET_N,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire [31:0] PTP_SEC,
  input  wire [29:0] PTP_NS,
  input  wire        GPIO_IN,
  output reg         GPIO_OUT,
  output reg         GPIO_OE,
  output reg         IRQ
);
  reg  [1:0]  trig_idx_ff;
  reg         cap_idx_ff;
  reg         out_sel_ff;
  reg         dir_ff;
  reg  [2:0]  trig_en_ff;
  reg  [2:0]  notify_ff;
  reg  [2:0]  done_ff;
  reg  [1:0]  cap_en_ff;
  reg  [1:0]  cap_irq_en_ff;
  reg  [1:0]  cap_rdy_ff;
  reg  [1:0]  cap_ovfl_ff;
  reg  [`CNT_W-1:0] cap_cnt0_ff;
  reg  [`CNT_W-1:0] cap_cnt1_ff;
  reg         pin_q_ff;
  reg         pulse_ff;
  reg  [4:0]  stat_ff;
  reg  [4:0]  mask_ff;
  reg  [11:0] aw_ff;
  reg         aw_have_ff;
  reg  [31:0] w_ff;
  reg  [3:0]  ws_ff;
  reg         w_have_ff;
  reg  [11:0] ar_ff;
  reg         rd_wait_ff;
  reg  [1:0]  unit_rr_ff;
  wire [29:0] tgt_ns;
  wire [31:0] tgt_s;
  wire        do_wr;
  wire        full_w;
  wire [31:0] wd;
  wire [2:0]  fire;
  wire [1:0]  cap_evt;
  reg  [31:0] rd_val;
  // true when every byte lane of the word is written
  function word_ok;
    input [3:0] s;
    begin
      word_ok = (s == 4'hf);
    end
  endfunction
  // one-hot of a 2-bit index
  function [2:0] onehot3;
    input [1:0] x;
    begin
      onehot3 = (x == 2'h0) ? 3'h1 : (x == 2'h1) ? 3'h2 : (x == 2'h2) ? 3'h4 : 3'h0;
    end
  endfunction
  // true for every mapped register address; both response paths use it
  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `A_CTRL) || (a == `A_TGT_NS) || (a == `A_TGT_S) || (a == `A_INDEX) ||
                (a == `A_IRQ_STAT) || (a == `A_IRQ_MASK) || (a == `A_DONE) || (a == `A_CNT);
    end
  endfunction
  assign do_wr  = aw_have_ff && w_have_ff && !S_AXI_BVALID;
  assign full_w = word_ok(ws_ff);
  assign wd     = w_ff;
  // target store; reads follow the indexed unit, fire compare walks units
  ptp_target_mem u_mem (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .we_ns    (do_wr && full_w && aw_ff == `A_TGT_NS),
    .we_s     (do_wr && full_w && aw_ff == `A_TGT_S),
    .widx     (trig_idx_ff),
    .wdata    (wd),
    .ridx     (rd_wait_ff ? trig_idx_ff : unit_rr_ff),
    .rd_ns_ff (tgt_ns),
    .rd_s_ff  (tgt_s)
  );
  // compare one unit per cycle; time at or past target fires it
  reg [1:0] cmp_unit_ff;
  assign fire = (trig_en_ff & onehot3(cmp_unit_ff)) &
                {3{(PTP_SEC > tgt_s) || (PTP_SEC == tgt_s && PTP_NS >= tgt_ns)}};
  // capture edge events on the gpio input when used as a timestamp input
  assign cap_evt = cap_en_ff & {2{!dir_ff && GPIO_IN && !pin_q_ff}};
  // axi write channel capture
  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      aw_ff         <= 12'h000;
      w_ff          <= `ZERO32;
      ws_ff         <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OK;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_have_ff && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_have_ff && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_ff      <= S_AXI_AWADDR;
        aw_have_ff <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_ff      <= S_AXI_WDATA;
        ws_ff     <= S_AXI_WSTRB;
        w_have_ff <= 1'b1;
      end
      if (do_wr)
      begin
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= addr_ok(aw_ff) ? `RESP_OK : `RESP_ERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end
  // read data mux for the indexed units
  always @*
  begin
    rd_val = `ZERO32;
    case (ar_ff)
      `A_CTRL:
      begin
        rd_val[`B_OUT_SEL] = out_sel_ff;
        rd_val[`B_PIN_IN]  = GPIO_IN;
        rd_val[`B_DIR]     = dir_ff;
        rd_val[`B_IRQ_EN]  = cap_irq_en_ff[cap_idx_ff];
        rd_val[`B_ACTIVE]  = (trig_idx_ff < 2'h3) && trig_en_ff[trig_idx_ff];
        rd_val[`B_TRIG_EN] = (trig_idx_ff < 2'h3) && trig_en_ff[trig_idx_ff];
        rd_val[`B_CAP_EN]  = cap_en_ff[cap_idx_ff];
      end
      `A_TGT_NS:   rd_val[`NS_W-1:0] = tgt_ns;
      `A_TGT_S:    rd_val = tgt_s;
      `A_INDEX:    rd_val = {23'h000000, cap_idx_ff, 6'h00, trig_idx_ff};
      `A_IRQ_STAT: rd_val[4:0] = stat_ff;
      `A_IRQ_MASK: rd_val[4:0] = mask_ff;
      `A_DONE:     rd_val = {27'h0000000, (trig_idx_ff < 2'h3) && notify_ff[trig_idx_ff],
                             1'b0, done_ff};
      `A_CNT:      rd_val = {cap_ovfl_ff, cap_rdy_ff, 4'h0, 8'h00, cap_cnt1_ff, cap_cnt0_ff};
      default:     rd_val = `ZERO32;
    endcase
  end
  // axi read channel; two wait cycles let the target store present the indexed word
  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= `ZERO32;
      S_AXI_RRESP   <= `RESP_OK;
      ar_ff         <= 12'h000;
      rd_wait_ff    <= 1'b0;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !rd_wait_ff && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        ar_ff      <= S_AXI_ARADDR;
        rd_wait_ff <= 1'b1;
      end
      else if (rd_wait_ff && unit_rr_ff == 2'h3)
      begin
        rd_wait_ff   <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_val;
        S_AXI_RRESP  <= addr_ok(ar_ff) ? `RESP_OK : `RESP_ERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end
  // compare pipeline: address then data one cycle later; read holds it at 3 once
  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      unit_rr_ff  <= 2'h0;
      cmp_unit_ff <= 2'h3;
    end
    else
    begin
      unit_rr_ff  <= rd_wait_ff ? 2'h3 : (unit_rr_ff == 2'h2) ? 2'h0 : unit_rr_ff + 2'h1;
      cmp_unit_ff <= rd_wait_ff ? 2'h3 : unit_rr_ff;
    end
  end
  // control, unit state and interrupt logic
  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      trig_idx_ff   <= 2'h0;
      cap_idx_ff    <= 1'b0;
      out_sel_ff    <= 1'b0;
      dir_ff        <= 1'b0;
      trig_en_ff    <= 3'h0;
      notify_ff     <= 3'h0;
      done_ff       <= 3'h0;
      cap_en_ff     <= 2'h0;
      cap_irq_en_ff <= 2'h0;
      cap_rdy_ff    <= 2'h0;
      cap_ovfl_ff   <= 2'h0;
      cap_cnt0_ff   <= 8'h00;
      cap_cnt1_ff   <= 8'h00;
      pin_q_ff      <= 1'b0;
      pulse_ff      <= 1'b0;
      stat_ff       <= 5'h00;
      mask_ff       <= 5'h00;
      GPIO_OUT      <= 1'b0;
      GPIO_OE       <= 1'b0;
      IRQ           <= 1'b0;
    end
    else
    begin
      pin_q_ff <= GPIO_IN;
      pulse_ff <= |fire;
      // fired units drop enable; notified ones set done
      trig_en_ff <= trig_en_ff & ~fire;
      done_ff    <= done_ff | (fire & notify_ff);
      // capture events count, latch ready and overflow
      if (cap_evt[0])
      begin
        cap_rdy_ff[0] <= 1'b1;
        {cap_ovfl_ff[0], cap_cnt0_ff} <= {cap_ovfl_ff[0], 8'h00} | ({1'b0, cap_cnt0_ff} + 9'h001);
      end
      if (cap_evt[1])
      begin
        cap_rdy_ff[1] <= 1'b1;
        {cap_ovfl_ff[1], cap_cnt1_ff} <= {cap_ovfl_ff[1], 8'h00} | ({1'b0, cap_cnt1_ff} + 9'h001);
      end
      // set wins over clear-on-read
      stat_ff[2:0] <= ((S_AXI_RVALID && S_AXI_RREADY && ar_ff == `A_IRQ_STAT) ?
                       3'h0 : stat_ff[2:0]) | (fire & notify_ff);
      stat_ff[4:3] <= ((S_AXI_RVALID && S_AXI_RREADY && ar_ff == `A_IRQ_STAT) ?
                       2'h0 : stat_ff[4:3]) | (cap_evt & cap_irq_en_ff);
      if (do_wr && full_w)
      begin
        case (aw_ff)
          `A_CTRL:
          begin
            out_sel_ff <= wd[`B_OUT_SEL];
            dir_ff     <= wd[`B_DIR];
            cap_irq_en_ff[cap_idx_ff] <= wd[`B_IRQ_EN] && !wd[`B_CAP_RST];
            if (trig_idx_ff < 2'h3)
            begin
              trig_en_ff[trig_idx_ff] <= wd[`B_TRIG_EN] && !wd[`B_TRIG_RST];
              if (wd[`B_TRIG_RST])
              begin
                notify_ff[trig_idx_ff] <= 1'b0;
                done_ff[trig_idx_ff]   <= 1'b0;
              end
            end
            cap_en_ff[cap_idx_ff] <= wd[`B_CAP_EN] && !wd[`B_CAP_RST];
            if (wd[`B_CAP_EN] || wd[`B_CAP_RST])
            begin
              if (cap_idx_ff)
                cap_cnt1_ff <= 8'h00;
              else
                cap_cnt0_ff <= 8'h00;
            end
            if (!wd[`B_CAP_EN] || wd[`B_CAP_RST])
            begin
              cap_rdy_ff[cap_idx_ff]  <= 1'b0;
              cap_ovfl_ff[cap_idx_ff] <= 1'b0;
            end
          end
          `A_INDEX:
          begin
            trig_idx_ff <= wd[1:0];
            cap_idx_ff  <= wd[`B_IDX_CAP];
          end
          `A_IRQ_MASK: mask_ff <= wd[4:0];
          `A_DONE:
          begin
            done_ff <= (done_ff & ~wd[2:0]) | (fire & notify_ff);
            if (trig_idx_ff < 2'h3)
              notify_ff[trig_idx_ff] <= wd[`B_NOTIFY];
          end
          default: ;
        endcase
      end
      // gpio drive: combinational path sees the fire cycle, flopped path one later
      GPIO_OE  <= dir_ff;
      GPIO_OUT <= dir_ff && (out_sel_ff ? |fire : pulse_ff);
      IRQ      <= |(stat_ff & mask_ff);
    end
  end
endmodule

//--- ptp_trig_consts.vh
// Purpose: constants for the gpio trigger / timestamp control block
// Assumes: axi4-lite byte addresses, 32-bit data
// Notes:   definitions only
`ifndef PTP_TRIG_CONSTS_VH
`define PTP_TRIG_CONSTS_VH
`define A_CTRL        12'h52c
`define A_TGT_NS      12'h530
`define A_TGT_S       12'h534
`define A_INDEX       12'h540
`define A_IRQ_STAT    12'h544
`define A_IRQ_MASK    12'h548
`define A_DONE        12'h54c
`define A_CNT         12'h550
`define B_OUT_SEL     8
`define B_PIN_IN      7
`define B_DIR         6
`define B_IRQ_EN      5
`define B_ACTIVE      4
`define B_TRIG_EN     3
`define B_TRIG_RST    2
`define B_CAP_EN      1
`define B_CAP_RST     0
`define B_IDX_CAP     8
`define B_NOTIFY      4
`define NS_W          30
`define CNT_W         8
`define N_TRIG        3
`define N_CAP         2
`define RESP_OK       2'h0
`define RESP_ERR      2'h2
`define ZERO32        32'h00000000
`endif

//--- ptp_target_mem.v
// Purpose: per-unit target time store (seconds and nanoseconds)
// Assumes: synchronous write, registered read
// Notes:   four words each, index 3 never compared by the top
`timescale 1ns/1ps
`include "ptp_trig_consts.vh"
module ptp_target_mem (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        we_ns,
  input  wire        we_s,
  input  wire [1:0]  widx,
  input  wire [31:0] wdata,
  input  wire [1:0]  ridx,
  output reg  [29:0] rd_ns_ff,
  output reg  [31:0] rd_s_ff
);
  reg [29:0] ns_mem [0:3];
  reg [31:0] s_mem  [0:3];
  integer    i;
  // storage with reset to zero
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        ns_mem[i] <= 30'h00000000;
        s_mem[i]  <= `ZERO32;
      end
      rd_ns_ff <= 30'h00000000;
      rd_s_ff  <= `ZERO32;
    end
    else
    begin
      if (we_ns)
        ns_mem[widx] <= wdata[`NS_W-1:0];
      if (we_s)
        s_mem[widx] <= wdata;
      rd_ns_ff <= ns_mem[ridx];
      rd_s_ff  <= s_mem[ridx];
    end
  end
endmodule

//--- ptp_trig_asserts.sv
// Purpose: port checks for the trigger control block
// Assumes: MCLK only, RESET_N async low
// Notes:   bound below the module
`timescale 1ns/1ps
`include "ptp_trig_consts.vh"
module ptp_trig_asserts (
  input wire        MCLK,
  input wire        RESET_N,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WREADY,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP,
  input wire        GPIO_OUT,
  input wire        GPIO_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // ready is a one-cycle answer to a request
  property p_aw_rdy; S_AXI_AWREADY |=> !S_AXI_AWREADY; endproperty
  a_aw_rdy: assert property (p_aw_rdy) else $error("awready held");
  property p_ar_rdy; S_AXI_ARREADY |=> !S_AXI_ARREADY; endproperty
  a_ar_rdy: assert property (p_ar_rdy) else $error("arready held");
  // answers come within the handed-over latency
  property p_b_due; S_AXI_AWREADY && S_AXI_WREADY |-> ##[1:4] S_AXI_BVALID; endproperty
  a_b_due: assert property (p_b_due) else $error("write response late");
  property p_r_due; S_AXI_ARVALID && S_AXI_ARREADY |-> ##[2:4] S_AXI_RVALID; endproperty
  a_r_due: assert property (p_r_due) else $error("read data late");
  // answers stand until taken
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // refused reads carry zero data
  property p_err0;
    S_AXI_RVALID && S_AXI_RRESP == `RESP_ERR |-> S_AXI_RDATA == `ZERO32;
  endproperty
  a_err0: assert property (p_err0) else $error("refused read with data");
  // pin driven only in trigger direction
  property p_oe; GPIO_OUT |-> GPIO_OE; endproperty
  a_oe: assert property (p_oe) else $error("pin pulsed while not driven");
  c_fire: cover property ($rose(GPIO_OUT));
  c_err: cover property (S_AXI_RVALID && S_AXI_RRESP == `RESP_ERR);
  c_bdone: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule
bind ptp_gpio_trigger_timestamp_ctrl ptp_trig_asserts u_chk (
  .MCLK          (MCLK),
  .RESET_N       (RESET_N),
  .S_AXI_AWVALID (S_AXI_AWVALID),
  .S_AXI_AWREADY (S_AXI_AWREADY),
  .S_AXI_WREADY  (S_AXI_WREADY),
  .S_AXI_BVALID  (S_AXI_BVALID),
  .S_AXI_BREADY  (S_AXI_BREADY),
  .S_AXI_ARVALID (S_AXI_ARVALID),
  .S_AXI_ARREADY (S_AXI_ARREADY),
  .S_AXI_RVALID  (S_AXI_RVALID),
  .S_AXI_RREADY  (S_AXI_RREADY),
  .S_AXI_RDATA   (S_AXI_RDATA),
  .S_AXI_RRESP   (S_AXI_RRESP),
  .GPIO_OUT      (GPIO_OUT),
  .GPIO_OE       (GPIO_OE)
);

//--- ptp_gpio_trigger_timestamp_ctrl_tb.sv
// Purpose: self-checking bench for the trigger control block
// Assumes: slave timing as handed over
// Notes:   bench drives the pin and ptp time itself
`timescale 1ns/1ps
`include "ptp_trig_consts.vh"
module ptp_gpio_trigger_timestamp_ctrl_tb;
  reg         clk, rst_n, awv, wv, bre, arv, rre, pin;
  reg  [11:0] awa, ara;
  reg  [31:0] wd, sec, d, i;
  reg  [29:0] ns;
  reg  [1:0]  r, br;
  wire        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, g_out, g_oe, irq;
  wire [1:0]  r_resp, b_resp;
  wire [31:0] r_data;
  integer     fails, n_tests;

  // block under test
  ptp_gpio_trigger_timestamp_ctrl dut (
    .MCLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_vld), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_vld), .S_AXI_RREADY(rre), .PTP_SEC(sec),
    .PTP_NS(ns), .GPIO_IN(pin), .GPIO_OUT(g_out), .GPIO_OE(g_oe), .IRQ(irq)
  );

  // 40 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare and count
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    #1000000;
    fails = fails + 1;
    report_and_stop;
  end

  // bus write: address and data offered together, each released when taken
  task put(input [11:0] a, input [31:0] v);
    reg aw, w;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw | w)
    begin
      @(posedge clk);
      if (aw_rdy) awv <= 1'b0;
      if (w_rdy) wv <= 1'b0;
      aw = aw & ~aw_rdy;
      w = w & ~w_rdy;
    end
    bre <= 1'b1;
    do @(posedge clk); while (!b_vld);
    br = b_resp;
    bre <= 1'b0;
  endtask

  // bus read into d and r, then a masked compare
  task gck(input string nm, input [11:0] a, input [31:0] m, input [31:0] e);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!ar_rdy);
    arv <= 1'b0;
    rre <= 1'b1;
    do @(posedge clk); while (!r_vld);
    d = r_data;
    r = r_resp;
    rre <= 1'b0;
    chk(nm, d & m, e);
  endtask

  // one rising edge on the pin
  task pulse;
    pin <= 1'b1;
    repeat (2) @(posedge clk);
    pin <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // reset values and a refused address
  task t_rst;
    gck("ctl", `A_CTRL, 32'hffffffff, 32'h0);
    gck("tns", `A_TGT_NS, 32'hffffffff, 32'h0);
    gck("ts", `A_TGT_S, 32'hffffffff, 32'h0);
    gck("err", 12'h600, 32'hffffffff, 32'h0);
    chk("resp", {30'h0, r}, {30'h0, `RESP_ERR});
    put(12'h600, 32'h0);
    chk("bresp", {30'h0, br}, {30'h0, `RESP_ERR});
  endtask

  // each trigger unit keeps its own target
  task t_tgt;
    for (i = 0; i < 3; i = i + 1)
    begin
      put(`A_INDEX, i);
      put(`A_TGT_NS, 32'hfffffff0 + i);
      put(`A_TGT_S, 32'ha5a50000 + i);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      put(`A_INDEX, i);
      gck("tns", `A_TGT_NS, 32'hffffffff, 32'h3ffffff0 + i);
      gck("ts", `A_TGT_S, 32'hffffffff, 32'ha5a50000 + i);
    end
  endtask

  // pin monitor, source select, drive direction
  task t_pin;
    pin <= 1'b1;
    put(`A_CTRL, 32'h140);
    gck("pin", `A_CTRL, 32'h1c0, 32'h1c0);
    chk("oe", {31'h0, g_oe}, 32'h1);
    pin <= 1'b0;
  endtask

  // arm, fire at target, done flag, masked then unmasked interrupt
  task t_fire;
    put(`A_INDEX, 32'h0);
    put(`A_DONE, 32'h10);
    put(`A_TGT_S, 32'h5);
    put(`A_TGT_NS, 32'h64);
    sec <= 32'h5;
    ns <= 30'h63;
    put(`A_CTRL, 32'h48);
    gck("arm", `A_CTRL, 32'h18, 32'h18);
    ns <= 30'h64;
    do @(posedge clk); while (!g_out);
    gck("idle", `A_CTRL, 32'h18, 32'h0);
    gck("done", `A_DONE, 32'h7, 32'h1);
    put(`A_DONE, 32'h11);
    gck("done", `A_DONE, 32'h7, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    put(`A_IRQ_MASK, 32'h1f);
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    gck("st", `A_IRQ_STAT, 32'h1f, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    ns <= 30'h63;
    put(`A_CTRL, 32'h148);
    ns <= 30'h64;
    do @(posedge clk); while (!g_out);
    gck("idle", `A_CTRL, 32'h18, 32'h0);
  endtask

  // soft reset stops an armed unit
  task t_srst;
    put(`A_INDEX, 32'h1);
    put(`A_CTRL, 32'h48);
    gck("arm", `A_CTRL, 32'h18, 32'h18);
    put(`A_CTRL, 32'h4c);
    gck("rst", `A_CTRL, 32'h1c, 32'h0);
  endtask

  // capture counting, interrupt gate and enable side effects
  task t_cap;
    put(`A_INDEX, 32'h0);
    put(`A_CTRL, 32'h22);
    repeat (3) pulse;
    gck("cnt", `A_CNT, 32'h100000ff, 32'h10000003);
    gck("st", `A_IRQ_STAT, 32'h18, 32'h8);
    put(`A_CTRL, 32'h22);
    gck("cnt", `A_CNT, 32'hff, 32'h0);
    put(`A_CTRL, 32'h0);
    gck("flg", `A_CNT, 32'hf0000000, 32'h0);
    put(`A_INDEX, 32'h100);
    put(`A_CTRL, 32'h2);
    pulse;
    gck("cnt", `A_CNT, 32'hffff, 32'h100);
    gck("st", `A_IRQ_STAT, 32'h18, 32'h0);
    put(`A_CTRL, 32'h3);
    gck("rst", `A_CTRL, 32'h3, 32'h0);
    gck("flg", `A_CNT, 32'h2000ff00, 32'h0);
  endtask

  // reset, then the scenarios in order
  initial
  begin
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    {awv, wv, bre, arv, rre, pin} = 6'h0;
    {awa, ara} = 24'h0;
    {wd, sec, ns} = 94'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_rst;
    t_tgt;
    t_pin;
    t_fire;
    t_srst;
    t_cap;
    report_and_stop;
  end
endmodule
